// [pkg/npc_pkg.sv]
// Constants, field layouts and carrier types of the nested page entry checker.
// Assumes a single core clock domain shared with the page walker.
package npc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Build options and entry layout.
  localparam int unsigned PHYS_ADDR_WIDTH = 46;
  localparam logic XO_SUPPORTED = 1'b1;
  localparam int unsigned PERM_LSB = 0;
  localparam int unsigned MTYPE_LSB = 3;
  localparam int unsigned PS_BIT = 7;
  localparam logic [2:0] PERM_WRITE_ONLY = 3'h2;
  localparam logic [2:0] PERM_WRITE_EXEC = 3'h6;
  localparam logic [2:0] PERM_EXEC_ONLY = 3'h4;
  localparam logic [2:0] PERM_NONE = 3'h0;
  localparam logic [2:0] PERM_ALL = 3'h7;
  localparam logic [2:0] MTYPE_RSVD_A = 3'h2;
  localparam logic [2:0] MTYPE_RSVD_B = 3'h3;
  localparam logic [2:0] MTYPE_RSVD_C = 3'h7;
  localparam logic [63:0] ADDR_TOP_LIMIT = 64'h0010_0000_0000_0000;
  localparam logic [63:0] ONE64 = 64'h0000_0000_0000_0001;
  localparam logic [63:0] ADDR_RSVD_MASK = ADDR_TOP_LIMIT - (ONE64 << PHYS_ADDR_WIDTH);
  localparam logic [63:0] NONLEAF_RSVD_MASK = 64'h0000_0000_0000_0078;
  localparam logic [63:0] TOP_PS_RSVD_MASK = 64'h0000_0000_0000_0080;
  localparam logic [63:0] PAGE_1G_RSVD_MASK = 64'h0000_0000_3FFF_F000;
  localparam logic [63:0] PAGE_2M_RSVD_MASK = 64'h0000_0000_001F_F000;

  // Walk levels: 0 page table, 1 directory, 2 directory pointer, 3 top level.
  localparam logic [1:0] LVL_PT = 2'h0;
  localparam logic [1:0] LVL_PD = 2'h1;
  localparam logic [1:0] LVL_PDP = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam logic [2:0] DIR_PTR_COUNT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CAP = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_PG = 1;
  localparam int unsigned CTRL_PAE = 2;
  localparam int unsigned CTRL_LMA = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int unsigned CAP_XO = 0;
  localparam int unsigned CAP_PAW_LSB = 8;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations and carriers.
  typedef enum logic [2:0] {
    KIND_DATA_READ = 3'h0,
    KIND_DATA_WRITE = 3'h1,
    KIND_FETCH = 3'h2,
    KIND_TABLE_READ = 3'h3,
    KIND_AD_UPDATE = 3'h4
  } npc_kind_t;

  typedef enum logic [1:0] {
    ACC_READ = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_FETCH = 2'h2
  } npc_access_t;

  typedef enum logic [1:0] {
    RES_OK = 2'h0,
    RES_MISCONFIG = 2'h1,
    RES_VIOLATION = 2'h2
  } npc_result_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WALK = 2'h1,
    ST_REPORT = 2'h3
  } npc_state_t;

  typedef struct packed {
    logic valid;
    logic start;
    logic [1:0] level;
    npc_kind_t kind;
    logic [63:0] entry;
  } npc_step_t;

  typedef struct packed {
    logic valid;
    npc_result_t result;
    npc_access_t access;
    logic [1:0] level;
    logic dir_ptr;
  } npc_report_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } npc_bus_t;

endpackage : npc_pkg

// [logic/npc_checker.sv]
// Nested page entry checker: judges every entry of a guest-physical walk.
// Assumes the walker presents one entry per valid step on the core clock,
// starting each walk with start high, and stops a walk once a report shows.
//
// Functional notes
// [R1] Permission bits holding write-only or write-plus-execute make a misconfiguration.
// [R2] Execute-only permission bits make a misconfiguration when that encoding is unsupported.
// [R3] A readable capability bit tells software whether execute-only entries are supported.
// [R4] A present entry with any reserved bit set, upper address bits included, is misconfigured.
// [R5] The final entry of a walk with memory type 2, 3 or 7 is misconfigured.
// [R6] A violation is reported only when the walk has no misconfiguration.
// [R7] Meeting a not-present entry is a violation.
// [R8] A data read is a violation if read permission is clear in any entry of the walk.
// [R9] Reads of guest page tables by the processor are checked as data reads.
// [R10] A data write is a violation if write permission is clear in any entry of the walk.
// [R11] Accessed and dirty flag updates by the processor are checked as data writes.
// [R12] A fetch is a violation if execute permission is clear in any entry of the walk.
// [R13] A base register load in the legacy extended-address mode fetches four pointer entries.
// [R14] A not-present entry has all other bits ignored and ends the walk.
// [R15] Faults arise only from real accesses, never from the base register load itself.
// [R16] Each walk yields one exclusive result together with the access type checked.
`timescale 1ns/1ps
`default_nettype none

module npc_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire npc_pkg::npc_step_t i_step,
  input wire logic i_base_load,
  input wire npc_pkg::npc_bus_t i_bus,
  output logic [31:0] o_rdata,
  output npc_pkg::npc_report_t o_report,
  output logic o_dir_ptr_req,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic npc_pkg::npc_access_t kind_to_access(input npc_pkg::npc_kind_t k);
    case (k)
      npc_pkg::KIND_DATA_WRITE: kind_to_access = npc_pkg::ACC_WRITE;
      npc_pkg::KIND_AD_UPDATE: kind_to_access = npc_pkg::ACC_WRITE; // see [R11]
      npc_pkg::KIND_FETCH: kind_to_access = npc_pkg::ACC_FETCH;
      npc_pkg::KIND_TABLE_READ: kind_to_access = npc_pkg::ACC_READ; // see [R9]
      default: kind_to_access = npc_pkg::ACC_READ;
    endcase
  endfunction : kind_to_access

  // The top level never maps a page, so its size bit is reserved instead.
  function automatic logic is_leaf(input logic [63:0] e, input logic [1:0] lvl);
    is_leaf = (lvl == npc_pkg::LVL_PT) ||
              ((lvl != npc_pkg::LVL_TOP) && e[npc_pkg::PS_BIT]);
  endfunction : is_leaf

  function automatic logic [63:0] rsvd_mask(input logic [1:0] lvl, input logic leaf);
    logic [63:0] m;
    m = npc_pkg::ADDR_RSVD_MASK;
    if (!leaf) begin
      m = m | npc_pkg::NONLEAF_RSVD_MASK;
      if (lvl == npc_pkg::LVL_TOP) begin
        m = m | npc_pkg::TOP_PS_RSVD_MASK;
      end
    end else if (lvl == npc_pkg::LVL_PDP) begin
      m = m | npc_pkg::PAGE_1G_RSVD_MASK;
    end else if (lvl == npc_pkg::LVL_PD) begin
      m = m | npc_pkg::PAGE_2M_RSVD_MASK;
    end
    rsvd_mask = m;
  endfunction : rsvd_mask

  // Only called for present entries, so a not-present entry never looks here.
  function automatic logic is_misconfig(input logic [63:0] e, input logic [1:0] lvl);
    logic [2:0] p;
    logic [2:0] mt;
    logic leaf;
    logic bad;
    p = e[npc_pkg::PERM_LSB +: 3];
    mt = e[npc_pkg::MTYPE_LSB +: 3];
    leaf = is_leaf(e, lvl);
    bad = 1'b0;
    if ((p == npc_pkg::PERM_WRITE_ONLY) || (p == npc_pkg::PERM_WRITE_EXEC)) begin
      bad = 1'b1; // see [R1]
    end
    if ((p == npc_pkg::PERM_EXEC_ONLY) && !npc_pkg::XO_SUPPORTED) begin
      bad = 1'b1; // see [R2]
    end
    if (|(e & rsvd_mask(lvl, leaf))) begin
      bad = 1'b1; // see [R4]
    end
    if (leaf && ((mt == npc_pkg::MTYPE_RSVD_A) || (mt == npc_pkg::MTYPE_RSVD_B) ||
                 (mt == npc_pkg::MTYPE_RSVD_C))) begin
      bad = 1'b1; // see [R5]
    end
    is_misconfig = bad;
  endfunction : is_misconfig

  function automatic logic perm_denies(input logic [2:0] p, input npc_pkg::npc_access_t a);
    case (a)
      npc_pkg::ACC_READ: perm_denies = !p[0]; // see [R8]
      npc_pkg::ACC_WRITE: perm_denies = !p[1]; // see [R10]
      npc_pkg::ACC_FETCH: perm_denies = !p[2]; // see [R12]
      default: perm_denies = 1'b1;
    endcase
  endfunction : perm_denies

  function automatic logic [15:0] sat_inc(input logic [15:0] c);
    sat_inc = (c == npc_pkg::COUNT_MAX) ? c : c + 16'h0001;
  endfunction : sat_inc

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    npc_pkg::npc_state_t st;
    logic [2:0] perm;
    npc_pkg::npc_access_t access;
    logic [3:0] ctrl;
    logic [2:0] dp_left;
    logic dp_walk;
    logic dp_req;
    npc_pkg::npc_report_t report;
    npc_pkg::npc_report_t last;
    logic [15:0] mis_count;
    logic [15:0] vio_count;
    logic [31:0] rdata;
    logic busy;
  } npc_core_t;

  npc_core_t s;
  npc_core_t next_s;

  always_comb begin
    logic accept;
    logic fresh;
    logic done;
    logic [2:0] perm_acc;
    npc_pkg::npc_access_t acc;
    npc_pkg::npc_result_t res;
    accept = 1'b0;
    fresh = 1'b0;
    done = 1'b0;
    perm_acc = npc_pkg::PERM_ALL;
    acc = s.access;
    res = npc_pkg::RES_OK;
    next_s = s;
    next_s.report = '0;
    next_s.rdata = 32'h0000_0000;

    // Register port: a read answers in the next cycle only.
    if (i_bus.wr && (i_bus.addr == npc_pkg::REG_CTRL)) begin
      next_s.ctrl = i_bus.wdata[3:0];
    end
    if (i_bus.wr && (i_bus.addr == npc_pkg::REG_COUNT)) begin
      next_s.mis_count = 16'h0000;
      next_s.vio_count = 16'h0000;
    end
    if (i_bus.rd) begin
      case (i_bus.addr)
        npc_pkg::REG_CTRL: next_s.rdata = {28'h000_0000, s.ctrl};
        npc_pkg::REG_STATUS: next_s.rdata = {19'h0_0000, s.dp_left, s.dp_walk,
                                             s.st != npc_pkg::ST_IDLE, s.last};
        npc_pkg::REG_CAP: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rdata[npc_pkg::CAP_XO] = npc_pkg::XO_SUPPORTED; // see [R3]
          next_s.rdata[npc_pkg::CAP_PAW_LSB +: 8] = 8'(npc_pkg::PHYS_ADDR_WIDTH);
        end
        npc_pkg::REG_COUNT: next_s.rdata = {s.vio_count, s.mis_count};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // The load itself raises nothing; only the pointer fetches it asks for can fault.
    if (i_base_load && s.ctrl[npc_pkg::CTRL_EN] && s.ctrl[npc_pkg::CTRL_PG] &&
        s.ctrl[npc_pkg::CTRL_PAE] && !s.ctrl[npc_pkg::CTRL_LMA]) begin
      next_s.dp_left = npc_pkg::DIR_PTR_COUNT; // see [R13] [R15]
      next_s.dp_req = 1'b1;
    end

    case (s.st)
      npc_pkg::ST_IDLE: begin
        accept = i_step.valid && i_step.start && s.ctrl[npc_pkg::CTRL_EN];
        fresh = 1'b1;
      end
      npc_pkg::ST_WALK: begin
        accept = i_step.valid && s.ctrl[npc_pkg::CTRL_EN];
        fresh = i_step.start;
      end
      npc_pkg::ST_REPORT: begin
        next_s.st = npc_pkg::ST_IDLE;
      end
      default: begin
        next_s.st = npc_pkg::ST_IDLE;
      end
    endcase

    if (accept) begin
      if (fresh) begin
        acc = kind_to_access(i_step.kind);
        next_s.access = acc;
        next_s.dp_walk = (s.dp_left != 3'h0);
      end
      perm_acc = (fresh ? npc_pkg::PERM_ALL : s.perm) & i_step.entry[npc_pkg::PERM_LSB +: 3];
      if (i_step.entry[npc_pkg::PERM_LSB +: 3] == npc_pkg::PERM_NONE) begin
        done = 1'b1; // see [R14]
        res = npc_pkg::RES_VIOLATION; // see [R7]
      end else if (is_misconfig(i_step.entry, i_step.level)) begin
        done = 1'b1;
        res = npc_pkg::RES_MISCONFIG;
      end else if (is_leaf(i_step.entry, i_step.level)) begin
        done = 1'b1;
        // Permissions are judged only once the whole walk is free of misconfigurations.
        res = perm_denies(perm_acc, acc) ? npc_pkg::RES_VIOLATION : npc_pkg::RES_OK; // see [R6]
      end else begin
        next_s.perm = perm_acc;
        next_s.st = npc_pkg::ST_WALK;
      end
    end

    if (done) begin
      next_s.st = npc_pkg::ST_REPORT;
      next_s.perm = npc_pkg::PERM_ALL;
      next_s.report.valid = 1'b1; // see [R16]
      next_s.report.result = res;
      next_s.report.access = acc;
      next_s.report.level = i_step.level;
      next_s.report.dir_ptr = fresh ? (s.dp_left != 3'h0) : s.dp_walk;
      next_s.last = next_s.report;
      if (res == npc_pkg::RES_MISCONFIG) begin
        next_s.mis_count = sat_inc(s.mis_count);
      end
      if (res == npc_pkg::RES_VIOLATION) begin
        next_s.vio_count = sat_inc(s.vio_count);
      end
      // A faulting pointer fetch abandons the rest of the set.
      if (next_s.report.dir_ptr) begin
        next_s.dp_left = (res == npc_pkg::RES_OK) ? s.dp_left - 3'h1 : 3'h0; // see [R13]
        next_s.dp_req = (res == npc_pkg::RES_OK) && (s.dp_left != 3'h1);
        next_s.dp_walk = 1'b0;
      end
    end
    // Kept as its own flip-flop so that the busy pin never comes from a comparator.
    next_s.busy = (next_s.st != npc_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      s <= '0;
      s.st <= npc_pkg::ST_IDLE;
      s.perm <= npc_pkg::PERM_ALL;
      s.ctrl <= npc_pkg::CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.

  always_comb begin
    o_rdata = s.rdata;
    o_report = s.report;
    o_dir_ptr_req = s.dp_req;
    o_busy = s.busy;
  end

endmodule : npc_checker

`default_nettype wire

// [tb/npc_checker_sva.sv]
// Port assertions for the nested page entry checker.
// Assumes it is bound to npc_checker and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module npc_checker_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire npc_pkg::npc_step_t i_step,
  input wire logic i_base_load,
  input wire npc_pkg::npc_bus_t i_bus,
  input wire logic [31:0] o_rdata,
  input wire npc_pkg::npc_report_t o_report,
  input wire logic o_dir_ptr_req,
  input wire logic o_busy
);
  logic [3:0] ctrl;
  logic [2:0] perm;
  logic [2:0] mt;
  assign perm = i_step.entry[2:0];
  assign mt = i_step.entry[5:3];
  // Shadow of the control register, so that taken steps can be told from ignored ones.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) ctrl <= 4'h0;
    else if (i_bus.wr && i_bus.addr == npc_pkg::REG_CTRL) ctrl <= i_bus.wdata[3:0];
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_take;
    i_step.valid && ctrl[0] && !o_report.valid && (o_busy || i_step.start);
  endsequence
  sequence s_misconf;
    o_report.valid && o_report.result == npc_pkg::RES_MISCONFIG;
  endsequence
  a_rdata_quiet: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not idle");
  a_cap_xo_bit: assert property (i_bus.rd && i_bus.addr == npc_pkg::REG_CAP
    |=> o_rdata[0] == npc_pkg::XO_SUPPORTED) else $error("capability bit wrong");
  a_report_pulse: assert property (o_report.valid |=> !o_report.valid)
    else $error("report longer than one cycle");
  a_report_clean: assert property (!o_report.valid |-> o_report == '0)
    else $error("report fields without valid");
  a_report_one_result: assert property (o_report.valid |-> o_report.result != 2'h3 && o_busy)
    else $error("report result illegal");
  a_absent_viol: assert property (s_take ##0 perm == npc_pkg::PERM_NONE |=> o_report.valid
    && o_report.result == npc_pkg::RES_VIOLATION && o_report.level == $past(i_step.level))
    else $error("absent entry not a violation");
  a_perm_misconf: assert property (s_take ##0 (perm == npc_pkg::PERM_WRITE_ONLY
    || perm == npc_pkg::PERM_WRITE_EXEC) |=> s_misconf) else $error("bad permission passed");
  a_addr_rsvd: assert property (s_take ##0 (perm != 3'h0
    && (i_step.entry & npc_pkg::ADDR_RSVD_MASK) != 64'h0) |=> s_misconf)
    else $error("upper address bit passed");
  a_mtype_rsvd: assert property (s_take ##0 (i_step.level == npc_pkg::LVL_PT && perm != 3'h0
    && (mt == 3'h2 || mt == 3'h3 || mt == 3'h7)) |=> s_misconf) else $error("memory type passed");
  a_ptr_load: assert property (i_base_load && ctrl == 4'h7 |=> o_dir_ptr_req)
    else $error("pointer fetch not started");
endmodule : npc_checker_sva
bind npc_checker npc_checker_sva u_npc_checker_sva (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .i_step(i_step), .i_base_load(i_base_load), .i_bus(i_bus), .o_rdata(o_rdata),
  .o_report(o_report), .o_dir_ptr_req(o_dir_ptr_req), .o_busy(o_busy));
`default_nettype wire

// [tb/npc_walker_model.sv]
// Page walker model: presents four entries, top level first, one per step.
// Assumes the checker's report ends the walk; slow mode leaves a gap between entries.
`timescale 1ns/1ps
`default_nettype none
module npc_walker_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_go,
  input wire logic i_slow,
  input wire npc_pkg::npc_kind_t i_kind,
  input wire logic [3:0][63:0] i_ents,
  input wire npc_pkg::npc_report_t i_report,
  output npc_pkg::npc_step_t o_step
);
  logic [2:0] idx;
  logic active;
  logic gap;
  // Between entries the data lines flip so that a stale entry is never mistaken for a fresh one.
  always @(posedge i_clk_sys) begin
    o_step.valid <= 1'b0;
    o_step.start <= 1'b0;
    o_step.entry <= ~o_step.entry;
    if (!i_rst_b) begin
      o_step <= '0;
      active <= 1'b0;
      idx <= 3'h0;
      gap <= 1'b0;
    end else if (i_go) begin
      active <= 1'b1;
      idx <= 3'h0;
      gap <= 1'b0;
    end else if (!active || i_report.valid || idx == 3'h4) begin
      active <= 1'b0;
    end else if (gap) begin
      gap <= 1'b0;
    end else begin
      o_step <= '{1'b1, idx == 3'h0, 2'h3 - idx[1:0], i_kind, i_ents[idx[1:0]]};
      idx <= idx + 3'h1;
      gap <= i_slow;
    end
  end
endmodule : npc_walker_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the nested page entry checker.
// Assumes the walker model and the port checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [63:0] NL = 64'h0000_0000_0000_0007;
  localparam logic [63:0] LF = 64'h0000_0000_0000_0037;
  logic clk, rst_b, go, slow, base_load;
  npc_pkg::npc_kind_t kind;
  logic [3:0][63:0] ents;
  npc_pkg::npc_step_t step;
  npc_pkg::npc_bus_t bus;
  npc_pkg::npc_report_t rep;
  logic [31:0] rdata, rd_v;
  logic ptr_req, busy;
  int err_total, tests_run, n_mis, n_vio;
  npc_checker u_npc_checker (.i_clk_sys(clk), .i_rst_b(rst_b), .i_step(step),
    .i_base_load(base_load), .i_bus(bus), .o_rdata(rdata), .o_report(rep),
    .o_dir_ptr_req(ptr_req), .o_busy(busy));
  npc_walker_model u_npc_walker_model (.i_clk_sys(clk), .i_rst_b(rst_b), .i_go(go),
    .i_slow(slow), .i_kind(kind), .i_ents(ents), .i_report(rep), .o_step(step));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 rd_v = rdata;
  endtask : rd
  // Entry p (0 is the top level) replaces the default walk; r of 3 means no report.
  task automatic walk(input npc_pkg::npc_kind_t k, input int p, input logic [63:0] v,
    input logic [1:0] r, input logic [1:0] l, input logic dp);
    npc_pkg::npc_report_t seen, ex;
    logic [3:0][63:0] e;
    logic [1:0] acc;
    e = {LF, NL, NL, NL};
    e[p] = v;
    acc = (k == npc_pkg::KIND_FETCH) ? 2'h2 : (k == npc_pkg::KIND_DATA_WRITE
      || k == npc_pkg::KIND_AD_UPDATE) ? 2'h1 : 2'h0;
    ex = (r == 2'h3) ? '0 : '{1'b1, npc_pkg::npc_result_t'(r), npc_pkg::npc_access_t'(acc), l, dp};
    seen = '0;
    n_mis += int'(r == 2'h1);
    n_vio += int'(r == 2'h2);
    @(posedge clk) ents <= e;
    kind <= k;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    for (int i = 0; i < 20 && seen.valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (rep.valid === 1'b1) seen = rep;
    end
    chk("report", 32'(ex), 32'(seen));
    @(posedge clk);
    #1 chk("busy", 32'h0000_0000, 32'(busy));
  endtask : walk
  task automatic load(input logic ex);
    @(posedge clk) base_load <= 1'b1;
    @(posedge clk) base_load <= 1'b0;
    #1 chk("dir_ptr_req", 32'(ex), 32'(ptr_req));
    chk("report_valid", 32'h0000_0000, 32'(rep.valid));
  endtask : load
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(npc_pkg::REG_CAP);
    chk("cap", {16'h0000, 8'(npc_pkg::PHYS_ADDR_WIDTH), 7'h00, 1'b1}, rd_v);
    wr(npc_pkg::REG_CAP, 32'h0000_0000);
    rd(8'h10);
    chk("unmapped", 32'h0000_0000, rd_v);
    rd(npc_pkg::REG_CAP);
    chk("cap_kept", {16'h0000, 8'(npc_pkg::PHYS_ADDR_WIDTH), 7'h00, 1'b1}, rd_v);
  endtask : t_regs
  task automatic t_perms;
    wr(npc_pkg::REG_CTRL, 32'h0000_0001);
    walk(npc_pkg::KIND_DATA_READ, 3, LF, 2'h0, 2'h0, 1'b0);
    walk(npc_pkg::KIND_FETCH, 2, 64'h0000_0000_0000_00B7, 2'h0, 2'h1, 1'b0);
    walk(npc_pkg::KIND_DATA_READ, 1, 64'h0000_0000_0000_0004, 2'h2, 2'h0, 1'b0);
    walk(npc_pkg::KIND_TABLE_READ, 0, 64'h0000_0000_0000_0006, 2'h1, 2'h3, 1'b0);
    walk(npc_pkg::KIND_TABLE_READ, 0, 64'h0000_0000_0000_0004, 2'h2, 2'h0, 1'b0);
    walk(npc_pkg::KIND_DATA_WRITE, 0, 64'h0000_0000_0000_0005, 2'h2, 2'h0, 1'b0);
    walk(npc_pkg::KIND_AD_UPDATE, 3, 64'h0000_0000_0000_0035, 2'h2, 2'h0, 1'b0);
    walk(npc_pkg::KIND_FETCH, 1, 64'h0000_0000_0000_0003, 2'h2, 2'h0, 1'b0);
    walk(npc_pkg::KIND_FETCH, 3, 64'h0000_0000_0000_0024, 2'h0, 2'h0, 1'b0);
    walk(npc_pkg::KIND_DATA_WRITE, 0, 64'hFFFF_FFFF_FFFF_FFF8, 2'h2, 2'h3, 1'b0);
    walk(npc_pkg::KIND_DATA_READ, 0, 64'h0000_0000_0000_0002, 2'h1, 2'h3, 1'b0);
    walk(npc_pkg::KIND_DATA_READ, 3, 64'h0000_2000_0000_0037, 2'h0, 2'h0, 1'b0);
    walk(npc_pkg::KIND_DATA_READ, 0, 64'h0000_4000_0000_0007, 2'h1, 2'h3, 1'b0);
  endtask : t_perms
  task automatic t_mtypes;
    @(posedge clk) slow <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      walk(npc_pkg::KIND_DATA_READ, 3, NL | 64'(m << 3),
        (m == 2 || m == 3 || m == 7) ? 2'h1 : 2'h0, 2'h0, 1'b0);
    end
    walk(npc_pkg::KIND_DATA_READ, 2, 64'h0000_0000_0000_00BF, 2'h1, 2'h1, 1'b0);
    @(posedge clk) slow <= 1'b0;
  endtask : t_mtypes
  task automatic t_count;
    rd(npc_pkg::REG_COUNT);
    chk("count", {n_vio[15:0], n_mis[15:0]}, rd_v);
    wr(npc_pkg::REG_COUNT, 32'h0000_0000);
    rd(npc_pkg::REG_COUNT);
    chk("count_clear", 32'h0000_0000, rd_v);
  endtask : t_count
  task automatic t_base;
    wr(npc_pkg::REG_CTRL, 32'h0000_0007);
    load(1'b1);
    // Four fetches left, idle, and the last report: a read misconfiguration at level 1.
    rd(npc_pkg::REG_STATUS);
    chk("status", 32'h0000_10A2, rd_v);
    for (int w = 0; w < 4; w++) walk(npc_pkg::KIND_DATA_READ, 3, LF, 2'h0, 2'h0, 1'b1);
    chk("dir_ptr_done", 32'h0000_0000, 32'(ptr_req));
    wr(npc_pkg::REG_CTRL, 32'h0000_000F);
    load(1'b0);
    wr(npc_pkg::REG_CTRL, 32'h0000_0000);
    walk(npc_pkg::KIND_DATA_READ, 0, 64'h0000_0000_0000_0002, 2'h3, 2'h0, 1'b0);
  endtask : t_base
  task automatic complete_run;
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rst_b, go, slow, base_load} = 5'h00;
    bus = '0;
    kind = npc_pkg::KIND_DATA_READ;
    ents = '0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_perms();
    t_mtypes();
    t_count();
    t_base();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
